// *** logic/dvd_pkg.sv ***
// constants shared by the data valid detector and its polling timer
// assumes: one 50 MHz clock, plain register port with 16-bit data
package dvd_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_MAIN_SETUP  = 8'h00;
	localparam logic [7:0] ADDR_POLL_ACTIVE = 8'h04;
	localparam logic [7:0] ADDR_POLL_SLEEP  = 8'h05;
	localparam logic [7:0] ADDR_RATE_LOW    = 8'h06;
	localparam logic [7:0] ADDR_RATE_HIGH   = 8'h07;
	localparam logic [7:0] ADDR_LEVEL_LIMIT = 8'h08;
	localparam logic [7:0] ADDR_DET_STATUS  = 8'h09;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int SLICER_SEL_BIT  = 15;
	localparam int CONT_MODE_BIT   = 5;
	localparam int SINGLE_MODE_BIT = 6;
	localparam int POLL_EN_BIT     = 0;

	// ----------------------------------------------------------------
	// values after reset
	// ----------------------------------------------------------------
	localparam logic [15:0] MAIN_SETUP_RST  = 16'h0000;
	localparam logic [15:0] POLL_ACTIVE_RST = 16'hfebf;
	localparam logic [15:0] POLL_SLEEP_RST  = 16'hf37f;
	localparam logic [11:0] RATE_LOW_RST    = 12'h000;
	localparam logic [11:0] RATE_HIGH_RST   = 12'h001;
	localparam logic [5:0]  LEVEL_LIMIT_RST = 6'h3f;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 20;
	localparam int SETTLE_TIME_NS = 2600000;
	localparam int SETTLE_CYC     =
		(SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int XTAL_DIV       = 4;
	localparam int WINDOW_PULSES  = 3;
endpackage

// *** logic/poll_timer.sv ***
// self-polling on/off timer counted on slow oscillator ticks
// assumes: tick is a one-cycle pulse already in the mclk domain
`timescale 1ns/1ns
`default_nettype none
module poll_timer #(
	parameter int W = 16
) (
	input  wire logic         mclk_in,
	input  wire logic         rst_b_in,
	input  wire logic         enable_in,
	input  wire logic         tick_in,
	input  wire logic [W-1:0] active_reload_in,
	input  wire logic [W-1:0] sleep_reload_in,
	output logic              active_out
);
	import dvd_pkg::*;

	logic [W-1:0] count_q;
	logic         wrap;

	// the tick that finds all bits above bit 0 set ends the phase
	assign wrap = &count_q[W-1:1];

	// ----------------------------------------------------------------
	// phase counter
	// ----------------------------------------------------------------
	// load, count up on each tick, swap phase once all bits above bit 0 are set
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			count_q    <= '0;
			active_out <= 1'b0;
		end else if (!enable_in) begin
			count_q    <= active_reload_in;
			active_out <= 1'b0;
		end else if (tick_in) begin
			if (wrap) begin
				active_out <= ~active_out;
				count_q    <= active_out ? sleep_reload_in
				                         : active_reload_in;
			end else begin
				count_q <= count_q + 1'b1;
			end
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);

	phase_swap_a: assert property (enable_in && tick_in && wrap
		|=> active_out != $past(active_out))
		else $error("poll phase did not swap at wrap");
	phase_hold_a: assert property (enable_in && !(tick_in && wrap)
		|=> active_out == $past(active_out))
		else $error("poll phase changed without wrap");
endmodule
`default_nettype wire

// *** logic/data_valid_detect.sv ***
// data valid detector, slicer source select, peak detector gating and
// self-polling timer registers
// assumes: mclk_in is the crystal clock; pins and rssi code are async
//
// Overview of operation
// - setup bit 15 picks integrator or peak source
// - peak detectors stay active under either source
// - peak detectors on only after whole receive path
// - detectors off: positive grounded, negative at supply
// - valid needs rate window and level threshold
// - setup bits 5 and 6 pick detection mode
// - no conversion before 2.6 ms settle enable
// - window done latches level compare, combines rate
// - ready for next conversion after three periods
// - rate from high time, single or double
// - decision spans three times two T
// - high time counted at crystal over four
// - rate limits reset to zero and one
// - level limit is 6-bit, linear to 1.2 V
// - level limit resets to all ones, inactive
// - reload is all ones minus oscillator ticks
// - poll reloads reset to 65215 and 62335
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module data_valid_detect #(
	parameter int SETTLE_CYCLES = dvd_pkg::SETTLE_CYC,
	parameter int CNT_W         = 13
) (
	input  wire logic        mclk_in,
	input  wire logic        rst_b_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic [15:0] wr_data_in,
	input  wire logic        wr_en_in,
	input  wire logic        rd_en_in,
	output logic      [15:0] rd_data_out,
	input  wire logic        rx_on_in,
	input  wire logic        rx_path_ready_in,
	input  wire logic        data_in,
	input  wire logic [5:0]  rssi_code_in,
	input  wire logic        slow_osc_in,
	output logic             slicer_peak_sel_out,
	output logic             pkd_enable_out,
	output logic             pkd_pos_gnd_out,
	output logic             pkd_neg_vcc_out,
	output logic             det_enable_out,
	output logic             window_done_out,
	output logic             data_valid_out,
	output logic             poll_active_out
);
	import dvd_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_WAIT_HIGH, ST_MEASURE,
		ST_HOLD} det_state_e;

	// ----------------------------------------------------------------
	// registers and state
	// ----------------------------------------------------------------
	logic [15:0]      setup_q;
	logic [15:0]      poll_active_q;
	logic [15:0]      poll_sleep_q;
	logic [11:0]      rate_low_q;
	logic [11:0]      rate_high_q;
	logic [5:0]       level_limit_q;
	logic [1:0]       rx_sync_q, path_sync_q, data_sync_q, osc_sync_q;
	logic [5:0]       rssi_meta_q, rssi_q;
	logic             data_prev_q, osc_prev_q;
	logic [21:0]      settle_cnt_q;
	logic [1:0]       div_q;
	logic             tick_q;
	logic [CNT_W-1:0] high_cnt_q;
	logic [1:0]       pulse_cnt_q;
	logic             single_ok_q, double_ok_q;
	logic             rate_ok_q, level_ok_q;
	det_state_e       state_q;
	logic             osc_tick;
	logic             data_rise, data_fall;
	logic             single_hit, double_hit;
	logic             rate_pass, level_pass;
	logic             cont_mode, single_mode, go;
	logic [CNT_W-1:0] lo_ext, hi_ext;

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	// two flops per async input before any logic looks at it
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rx_sync_q   <= 2'h0;
			path_sync_q <= 2'h0;
			data_sync_q <= 2'h0;
			osc_sync_q  <= 2'h0;
			rssi_meta_q <= 6'h00;
			rssi_q      <= 6'h00;
			data_prev_q <= 1'b0;
			osc_prev_q  <= 1'b0;
		end else begin
			rx_sync_q   <= {rx_sync_q[0], rx_on_in};
			path_sync_q <= {path_sync_q[0], rx_path_ready_in};
			data_sync_q <= {data_sync_q[0], data_in};
			osc_sync_q  <= {osc_sync_q[0], slow_osc_in};
			rssi_meta_q <= rssi_code_in;
			rssi_q      <= rssi_meta_q;
			data_prev_q <= data_sync_q[1];
			osc_prev_q  <= osc_sync_q[1];
		end
	end

	assign osc_tick  = osc_sync_q[1] & ~osc_prev_q;
	assign data_rise = data_sync_q[1] & ~data_prev_q;
	assign data_fall = ~data_sync_q[1] & data_prev_q;

	// ----------------------------------------------------------------
	// register write port
	// ----------------------------------------------------------------
	// bits above the rate and level limit widths are dropped on write and read back as zero
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			setup_q       <= MAIN_SETUP_RST;
			poll_active_q <= POLL_ACTIVE_RST;
			poll_sleep_q  <= POLL_SLEEP_RST;
			rate_low_q    <= RATE_LOW_RST;
			rate_high_q   <= RATE_HIGH_RST;
			level_limit_q <= LEVEL_LIMIT_RST;
		end else if (wr_en_in) begin
			case (addr_in)
				ADDR_MAIN_SETUP:  setup_q       <= wr_data_in;
				ADDR_POLL_ACTIVE: poll_active_q <= wr_data_in;
				ADDR_POLL_SLEEP:  poll_sleep_q  <= wr_data_in;
				ADDR_RATE_LOW:    rate_low_q    <= wr_data_in[11:0];
				ADDR_RATE_HIGH:   rate_high_q   <= wr_data_in[11:0];
				ADDR_LEVEL_LIMIT: level_limit_q <= wr_data_in[5:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// register read port
	// ----------------------------------------------------------------
	// data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_data_out <= 16'h0000;
		end else if (rd_en_in) begin
			case (addr_in)
				ADDR_MAIN_SETUP:  rd_data_out <= setup_q;
				ADDR_POLL_ACTIVE: rd_data_out <= poll_active_q;
				ADDR_POLL_SLEEP:  rd_data_out <= poll_sleep_q;
				ADDR_RATE_LOW:    rd_data_out <= {4'h0, rate_low_q};
				ADDR_RATE_HIGH:   rd_data_out <= {4'h0, rate_high_q};
				ADDR_LEVEL_LIMIT: rd_data_out <= {10'h000, level_limit_q};
				ADDR_DET_STATUS:  rd_data_out <= {10'h000,
					poll_active_out, det_enable_out,
					(state_q != ST_IDLE && state_q != ST_HOLD),
					level_ok_q, rate_ok_q, data_valid_out};
				default:          rd_data_out <= 16'h0000;
			endcase
		end else begin
			rd_data_out <= 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// slicer source and peak detector gating
	// ----------------------------------------------------------------
	// source select touches only the slicer; detectors follow the path
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			slicer_peak_sel_out <= 1'b0;
			pkd_enable_out      <= 1'b0;
			pkd_pos_gnd_out     <= 1'b1;
			pkd_neg_vcc_out     <= 1'b1;
		end else begin
			slicer_peak_sel_out <= setup_q[SLICER_SEL_BIT];
			pkd_enable_out  <= rx_sync_q[1] & path_sync_q[1];
			pkd_pos_gnd_out <= ~(rx_sync_q[1] & path_sync_q[1]);
			pkd_neg_vcc_out <= ~(rx_sync_q[1] & path_sync_q[1]);
		end
	end

	// ----------------------------------------------------------------
	// settle delay before detection may start
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			settle_cnt_q   <= 22'h000000;
			det_enable_out <= 1'b0;
		end else if (!rx_sync_q[1]) begin
			settle_cnt_q   <= 22'h000000;
			det_enable_out <= 1'b0;
		end else if (settle_cnt_q == 22'(SETTLE_CYCLES - 1)) begin
			det_enable_out <= 1'b1;
		end else begin
			settle_cnt_q <= settle_cnt_q + 22'h000001;
		end
	end

	// ----------------------------------------------------------------
	// crystal divide by four tick
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			div_q  <= 2'h0;
			tick_q <= 1'b0;
		end else begin
			div_q  <= div_q + 2'h1;
			tick_q <= (div_q == 2'(XTAL_DIV - 1));
		end
	end

	// ----------------------------------------------------------------
	// rate window compare
	// ----------------------------------------------------------------
	// a high time passes at the limits, or at twice them for manchester
	assign lo_ext     = {{(CNT_W-12){1'b0}}, rate_low_q};
	assign hi_ext     = {{(CNT_W-12){1'b0}}, rate_high_q};
	assign single_hit = high_cnt_q >= lo_ext && high_cnt_q <= hi_ext;
	assign double_hit = high_cnt_q >= (lo_ext << 1)
		&& high_cnt_q <= (hi_ext << 1);
	// a low limit of zero, its default, leaves the rate window out of the decision
	assign rate_pass  = (rate_low_q == RATE_LOW_RST) ||
		(single_ok_q && single_hit) || (double_ok_q && double_hit);
	// all-ones limit leaves the level check out of the decision
	assign level_pass = (level_limit_q == LEVEL_LIMIT_RST) ||
		(rssi_q >= level_limit_q);

	assign cont_mode   = setup_q[CONT_MODE_BIT];
	assign single_mode = setup_q[SINGLE_MODE_BIT];
	assign go          = det_enable_out && rx_sync_q[1]
		&& (cont_mode || single_mode);

	// ----------------------------------------------------------------
	// conversion sequence
	// ----------------------------------------------------------------
	// three high phases make one window of three data periods
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q     <= ST_IDLE;
			high_cnt_q  <= '0;
			pulse_cnt_q <= 2'h0;
			single_ok_q <= 1'b0;
			double_ok_q <= 1'b0;
		end else if (!go) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					pulse_cnt_q <= 2'h0;
					single_ok_q <= 1'b1;
					double_ok_q <= 1'b1;
					state_q     <= ST_WAIT_HIGH;
				end
				ST_WAIT_HIGH: begin
					high_cnt_q <= '0;
					if (data_rise) begin
						state_q <= ST_MEASURE;
					end
				end
				ST_MEASURE: begin
					if (data_fall) begin
						single_ok_q <= single_ok_q & single_hit;
						double_ok_q <= double_ok_q & double_hit;
						if (pulse_cnt_q == 2'(WINDOW_PULSES - 1)) begin
							state_q <= ST_HOLD;
						end else begin
							pulse_cnt_q <= pulse_cnt_q + 2'h1;
							state_q     <= ST_WAIT_HIGH;
						end
					end else if (tick_q && !(&high_cnt_q)) begin
						high_cnt_q <= high_cnt_q + 1'b1;
					end
				end
				ST_HOLD: begin
					if (cont_mode && !single_mode) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// window done and result latch
	// ----------------------------------------------------------------
	// results hold until the receiver switches off or the next window
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			window_done_out <= 1'b0;
			rate_ok_q       <= 1'b0;
			level_ok_q      <= 1'b0;
			data_valid_out  <= 1'b0;
		end else if (!rx_sync_q[1]) begin
			window_done_out <= 1'b0;
			rate_ok_q       <= 1'b0;
			level_ok_q      <= 1'b0;
			data_valid_out  <= 1'b0;
		end else begin
			window_done_out <= go && state_q == ST_MEASURE && data_fall
				&& pulse_cnt_q == 2'(WINDOW_PULSES - 1);
			if (window_done_out) begin
				rate_ok_q      <= rate_pass;
				level_ok_q     <= level_pass;
				data_valid_out <= rate_pass & level_pass;
			end
		end
	end

	// ----------------------------------------------------------------
	// self-polling timer
	// ----------------------------------------------------------------
	poll_timer #(
		.W(16)
	) u_poll (
		.mclk_in          (mclk_in),
		.rst_b_in         (rst_b_in),
		.enable_in        (setup_q[POLL_EN_BIT]),
		.tick_in          (osc_tick),
		.active_reload_in (poll_active_q),
		.sleep_reload_in  (poll_sleep_q),
		.active_out       (poll_active_out)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking dc @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);

	sequence four_cycle_tick;
		!tick_q [*3] ##1 tick_q;
	endsequence

	slicer_select_a: assert property (wr_en_in && addr_in ==
		ADDR_MAIN_SETUP |=> ##1 slicer_peak_sel_out ==
		$past(wr_data_in[SLICER_SEL_BIT], 2))
		else $error("slicer select did not follow setup write");
	pkd_force_a: assert property (!pkd_enable_out |->
		pkd_pos_gnd_out && pkd_neg_vcc_out)
		else $error("peak outputs not forced while off");
	pkd_order_a: assert property ($rose(pkd_enable_out) |->
		$past(path_sync_q[1]) && $past(rx_sync_q[1]))
		else $error("peak detector on before receive path");
	settle_gate_a: assert property (state_q != ST_IDLE |->
		det_enable_out && settle_cnt_q == 22'(SETTLE_CYCLES - 1))
		else $error("conversion running before settle enable");
	tick_div_a: assert property (tick_q |=> four_cycle_tick)
		else $error("count tick not crystal over four");
	valid_combine_a: assert property (window_done_out && rx_sync_q[1]
		|=> data_valid_out == $past(rate_pass && level_pass))
		else $error("data valid not latched at window done");
	level_latch_a: assert property (window_done_out && rx_sync_q[1]
		|=> level_ok_q == $past(level_pass))
		else $error("level compare not latched at window done");
	level_default_a: assert property (window_done_out && rx_sync_q[1]
		&& level_limit_q == 6'h3f |=> level_ok_q)
		else $error("all-ones level limit did not bypass level");
	single_hold_a: assert property (state_q == ST_HOLD && go
		&& single_mode |=> state_q == ST_HOLD)
		else $error("single shot did not hold its result");
	window_len_a: assert property (window_done_out |->
		$past(pulse_cnt_q) == 2'(WINDOW_PULSES - 1))
		else $error("window ended before three high phases");
endmodule
`default_nettype wire

// *** sim/data_valid_detect_tb_top.sv ***
// self-checking bench for the data valid detector and its poll timer
// assumes: dvd_pkg and the design files are compiled before this file
`timescale 1ns/1ns
`default_nettype none
module data_valid_detect_tb_top;
	import dvd_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam int SETTLE = 20;
	localparam int LO     = 10;
	localparam int HI     = 20;
	localparam int LEV    = 32;
	logic        mclk_in          = 1'b0;
	logic        rst_b_in         = 1'b0;
	logic [7:0]  addr_in          = 8'h00;
	logic [15:0] wr_data_in       = 16'h0000;
	logic        wr_en_in         = 1'b0;
	logic        rd_en_in         = 1'b0;
	logic        rx_on_in         = 1'b0;
	logic        rx_path_ready_in = 1'b0;
	logic        data_in          = 1'b0;
	logic [5:0]  rssi_code_in     = 6'h00;
	logic        slow_osc_in      = 1'b0;
	logic [15:0] rd_data_out;
	logic        slicer_peak_sel_out;
	logic        pkd_enable_out;
	logic        pkd_pos_gnd_out;
	logic        pkd_neg_vcc_out;
	logic        det_enable_out;
	logic        window_done_out;
	logic        data_valid_out;
	logic        poll_active_out;
	int          failures   = 0;
	int          n_compared = 0;
	int          n_win      = 0;
	int          ht;
	int          n0;
	logic [15:0] v;
	logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
	logic [15:0] rv [6] = '{16'h0000, 16'hfebf, 16'hf37f, 16'h0000,
		16'h0001, 16'h003f};
	int          pt [6] = '{1, 1, 1, 1, 2, 1};
	logic        pv [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

	data_valid_detect #(
		.SETTLE_CYCLES(SETTLE)
	) u_dut (
		.mclk_in            (mclk_in),
		.rst_b_in           (rst_b_in),
		.addr_in            (addr_in),
		.wr_data_in         (wr_data_in),
		.wr_en_in           (wr_en_in),
		.rd_en_in           (rd_en_in),
		.rd_data_out        (rd_data_out),
		.rx_on_in           (rx_on_in),
		.rx_path_ready_in   (rx_path_ready_in),
		.data_in            (data_in),
		.rssi_code_in       (rssi_code_in),
		.slow_osc_in        (slow_osc_in),
		.slicer_peak_sel_out(slicer_peak_sel_out),
		.pkd_enable_out     (pkd_enable_out),
		.pkd_pos_gnd_out    (pkd_pos_gnd_out),
		.pkd_neg_vcc_out    (pkd_neg_vcc_out),
		.det_enable_out     (det_enable_out),
		.window_done_out    (window_done_out),
		.data_valid_out     (data_valid_out),
		.poll_active_out    (poll_active_out)
	);

	// 50 MHz clock
	always #10 mclk_in = ~mclk_in;

	// count window done pulses
	always @(posedge mclk_in) begin
		if (window_done_out === 1'b1)
			n_win <= n_win + 1;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic exp_valid(input int h, input int r);
		logic rate;
		rate = (h >= LO && h <= HI) || (h >= 2 * LO && h <= 2 * HI);
		return rate && (r >= LEV);
	endfunction

	task automatic chk(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic chk1(input string name, input logic exp, input logic got);
		chk(name, {15'h0000, exp}, {15'h0000, got});
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk_in);
		wr_en_in   <= 1'b1;
		addr_in    <= a;
		wr_data_in <= d;
		@(posedge mclk_in);
		wr_en_in <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge mclk_in);
		rd_en_in <= 1'b1;
		addr_in  <= a;
		@(posedge mclk_in);
		rd_en_in <= 1'b0;
		#1;
		chk("read data", exp, rd_data_out);
	endtask

	// n high phases of h crystal-over-four ticks each
	task automatic pulses(input int n, input int h);
		repeat (n) begin
			@(posedge mclk_in);
			data_in <= 1'b1;
			repeat (h * XTAL_DIV) @(posedge mclk_in);
			data_in <= 1'b0;
			repeat (40) @(posedge mclk_in);
		end
	endtask

	// drop and raise receive, check the settle enable edge
	task automatic rx_start();
		@(posedge mclk_in);
		rx_on_in <= 1'b0;
		repeat (4) @(posedge mclk_in);
		rx_on_in         <= 1'b1;
		rx_path_ready_in <= 1'b1;
		repeat (SETTLE - 2) @(posedge mclk_in);
		#1;
		chk1("det_enable early", 1'b0, det_enable_out);
		repeat (12) @(posedge mclk_in);
		#1;
		chk1("det_enable", 1'b1, det_enable_out);
		@(posedge mclk_in);
	endtask

	task automatic win(input int h, input int r, input int nw);
		rssi_code_in <= r[5:0];
		n0 = n_win;
		pulses(WINDOW_PULSES, h);
		chk("windows", nw[15:0], n_win - n0);
		chk1("data_valid", exp_valid(h, r), data_valid_out);
	endtask

	task automatic tick();
		@(posedge mclk_in);
		slow_osc_in <= 1'b1;
		repeat (4) @(posedge mclk_in);
		slow_osc_in <= 1'b0;
		repeat (4) @(posedge mclk_in);
	endtask

	task automatic end_of_test();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	// watchdog against a hang
	initial begin
		#600000;
		failures++;
		end_of_test();
	end

	// main sequence
	initial begin
		void'($urandom(20));
		repeat (2) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		#1;
		chk1("pos_gnd", 1'b1, pkd_pos_gnd_out);
		chk1("neg_vcc", 1'b1, pkd_neg_vcc_out);
		for (int i = 0; i < 6; i++)
			rd(ra[i], rv[i]);
		rd(8'h0a, 16'h0000);
		// peak detector gating and slicer source
		wr(8'h00, 16'h8000);
		@(posedge mclk_in);
		#1;
		chk1("slicer_sel", 1'b1, slicer_peak_sel_out);
		@(posedge mclk_in);
		rx_on_in <= 1'b1;
		repeat (6) @(posedge mclk_in);
		#1;
		chk1("pkd_enable early", 1'b0, pkd_enable_out);
		chk1("pos_gnd off", 1'b1, pkd_pos_gnd_out);
		@(posedge mclk_in);
		rx_path_ready_in <= 1'b1;
		repeat (6) @(posedge mclk_in);
		#1;
		chk1("pkd_enable", 1'b1, pkd_enable_out);
		chk1("neg_vcc on", 1'b0, pkd_neg_vcc_out);
		chk1("pos_gnd on", 1'b0, pkd_pos_gnd_out);
		// defaults leave both criteria inactive, single shot holds
		wr(8'h00, 16'h0040);
		#1;
		chk1("pkd_enable lp", 1'b1, pkd_enable_out);
		rx_start();
		rssi_code_in <= 6'h00;
		n0 = n_win;
		pulses(WINDOW_PULSES, 50);
		chk1("default valid", 1'b1, data_valid_out);
		pulses(WINDOW_PULSES, 15);
		chk("single shot", 16'h0001, n_win - n0);
		// limit registers drop bits above their width
		wr(8'h06, 16'hffff);
		wr(8'h07, 16'hffff);
		wr(8'h08, 16'hffff);
		rd(8'h06, 16'h0fff);
		rd(8'h07, 16'h0fff);
		rd(8'h08, 16'h003f);
		v = 16'($urandom);
		wr(8'h04, v);
		rd(8'h04, v);
		wr(8'h05, ~v);
		rd(8'h05, ~v);
		wr(8'h06, 16'(LO));
		wr(8'h07, 16'(HI));
		wr(8'h08, 16'(LEV));
		// random windows with level boundary corners first
		for (int i = 0; i < 8; i++) begin
			case ($urandom_range(3, 0))
				0: ht = $urandom_range(18, 12);
				1: ht = $urandom_range(37, 23);
				2: ht = $urandom_range(7, 2);
				default: ht = $urandom_range(60, 45);
			endcase
			rx_start();
			if (i < 2)
				win(ht, LEV - i, 1);
			else
				win(ht, $urandom_range(63, 0), 1);
		end
		// continuous mode restarts, receive off clears the result
		wr(8'h00, 16'h0020);
		rx_start();
		rssi_code_in <= 6'h3f;
		n0 = n_win;
		pulses(2 * WINDOW_PULSES, 15);
		chk("continuous", 16'h0002, n_win - n0);
		chk1("cont valid", 1'b1, data_valid_out);
		rd(ADDR_DET_STATUS, 16'h001f);
		rx_on_in <= 1'b0;
		repeat (6) @(posedge mclk_in);
		#1;
		chk1("valid cleared", 1'b0, data_valid_out);
		// neither mode bit set: no conversion
		wr(8'h00, 16'h0000);
		rx_start();
		n0 = n_win;
		pulses(WINDOW_PULSES, 15);
		chk("mode off", 16'h0000, n_win - n0);
		// polling phases from short reloads
		wr(8'h04, 16'hfffd);
		wr(8'h05, 16'hfffc);
		wr(8'h00, 16'h0001);
		for (int i = 0; i < 6; i++) begin
			repeat (pt[i]) tick();
			#1;
			chk1("poll_active", pv[i], poll_active_out);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
